//--- shas_pkg.sv
`default_nettype none
package shas_pkg;
   // register byte offset within the block's APB window
   localparam logic [11:0] SHAS_STATE_OFFSET = 12'hd24;
   // flag positions
   localparam int SHAS_MEM_BIT = 0;
   localparam int SHAS_BUS_BIT = 1;
   localparam int SHAS_USG_BIT = 3;
   localparam int SHAS_SVC_BIT = 7;
   localparam int SHAS_DBG_BIT = 8;
   localparam int SHAS_PSV_BIT = 10;
   localparam logic [31:0] SHAS_STATE_RESET = 32'h0000_0000;
   localparam logic [31:0] SHAS_RW_MASK = 32'h0000_058b;

   // one bit per handler, in this order
   typedef struct packed {
      logic pendable_service;
      logic debug_monitor;
      logic supervisor_call;
      logic usage_fault;
      logic bus_fault;
      logic memory_fault;
   } shas_flags_type;
endpackage
`default_nettype wire

//--- shas_system_handler_active_status.sv
`timescale 1ns/1ps
`default_nettype none
module shas_system_handler_active_status
   import shas_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // exception logic, one-cycle pulses per handler
   input wire shas_flags_type handler_enter,
   input wire shas_flags_type handler_return,
   // current active flags
   output shas_flags_type active_flags
);
   logic wr_hit;
   logic rd_hit;
   logic addr_ok;
   shas_flags_type sw_value;
   logic [31:0] state_word;
   logic pendable_service_active;
   logic debug_monitor_active;
   logic supervisor_call_active;
   logic usage_fault_active;
   logic bus_fault_active;
   logic memory_fault_active;

   assign addr_ok = (paddr == SHAS_STATE_OFFSET);
   assign wr_hit = psel && penable && pwrite && addr_ok;
   assign rd_hit = psel && penable && !pwrite && addr_ok;
   // zero-wait slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   assign sw_value = '{pendable_service: pwdata[SHAS_PSV_BIT],
                       debug_monitor: pwdata[SHAS_DBG_BIT],
                       supervisor_call: pwdata[SHAS_SVC_BIT],
                       usage_fault: pwdata[SHAS_USG_BIT],
                       bus_fault: pwdata[SHAS_BUS_BIT],
                       memory_fault: pwdata[SHAS_MEM_BIT]};

   // entry beats return, return beats a same-cycle write:
   // hardware state must never be lost to a racing software store

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pendable_service_active <= 1'b0;
      end
      else if (handler_enter.pendable_service)
      begin
         pendable_service_active <= 1'b1;
      end
      else if (handler_return.pendable_service)
      begin
         pendable_service_active <= 1'b0;
      end
      else if (wr_hit)
      begin
         pendable_service_active <= sw_value.pendable_service;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         debug_monitor_active <= 1'b0;
      end
      else if (handler_enter.debug_monitor)
      begin
         debug_monitor_active <= 1'b1;
      end
      else if (handler_return.debug_monitor)
      begin
         debug_monitor_active <= 1'b0;
      end
      else if (wr_hit)
      begin
         debug_monitor_active <= sw_value.debug_monitor;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         supervisor_call_active <= 1'b0;
      end
      else if (handler_enter.supervisor_call)
      begin
         supervisor_call_active <= 1'b1;
      end
      else if (handler_return.supervisor_call)
      begin
         supervisor_call_active <= 1'b0;
      end
      else if (wr_hit)
      begin
         supervisor_call_active <= sw_value.supervisor_call;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         usage_fault_active <= 1'b0;
      end
      else if (handler_enter.usage_fault)
      begin
         usage_fault_active <= 1'b1;
      end
      else if (handler_return.usage_fault)
      begin
         usage_fault_active <= 1'b0;
      end
      else if (wr_hit)
      begin
         usage_fault_active <= sw_value.usage_fault;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_fault_active <= 1'b0;
      end
      else if (handler_enter.bus_fault)
      begin
         bus_fault_active <= 1'b1;
      end
      else if (handler_return.bus_fault)
      begin
         bus_fault_active <= 1'b0;
      end
      else if (wr_hit)
      begin
         bus_fault_active <= sw_value.bus_fault;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         memory_fault_active <= 1'b0;
      end
      else if (handler_enter.memory_fault)
      begin
         memory_fault_active <= 1'b1;
      end
      else if (handler_return.memory_fault)
      begin
         memory_fault_active <= 1'b0;
      end
      else if (wr_hit)
      begin
         memory_fault_active <= sw_value.memory_fault;
      end
   end

   // flags gathered for the exception logic
   assign active_flags = '{pendable_service: pendable_service_active,
                           debug_monitor: debug_monitor_active,
                           supervisor_call: supervisor_call_active,
                           usage_fault: usage_fault_active,
                           bus_fault: bus_fault_active,
                           memory_fault: memory_fault_active};

   always_comb
   begin
      state_word = SHAS_STATE_RESET;
      state_word[SHAS_PSV_BIT] = active_flags.pendable_service;
      state_word[SHAS_DBG_BIT] = active_flags.debug_monitor;
      state_word[SHAS_SVC_BIT] = active_flags.supervisor_call;
      state_word[SHAS_USG_BIT] = active_flags.usage_fault;
      state_word[SHAS_BUS_BIT] = active_flags.bus_fault;
      state_word[SHAS_MEM_BIT] = active_flags.memory_fault;
   end

   // read data from a flop, loaded in the setup cycle so it is valid in access
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata <= '0;
      end
      else if (psel && !penable && !pwrite && paddr == SHAS_STATE_OFFSET)
      begin
         prdata <= state_word;
      end
      else if (!psel)
      begin
         prdata <= '0;
      end
   end

   shas_flags_type past_wval;
   always_ff @(posedge sys_clk)
   begin
      past_wval <= sw_value;
   end

   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (prdata & ~SHAS_RW_MASK) == 32'h0) else $error("reserved bits nonzero");
   write_psv_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_hit && handler_enter == '0 && handler_return == '0 |=>
      active_flags.pendable_service == past_wval.pendable_service && active_flags == past_wval)
      else $error("write did not update flags");
   // read data was captured in the setup cycle, so compare with the flags of then
   dbg_readback_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      rd_hit |-> prdata[SHAS_DBG_BIT] == $past(active_flags.debug_monitor))
      else $error("monitor readback wrong");
   svc_readback_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      rd_hit |-> prdata[SHAS_SVC_BIT] == $past(active_flags.supervisor_call))
      else $error("svc readback wrong");
   usage_enter_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      handler_enter.usage_fault |=> active_flags.usage_fault)
      else $error("usage flag not set");
   bus_return_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      handler_return.bus_fault && !handler_enter.bus_fault && !wr_hit |=>
      !active_flags.bus_fault) else $error("bus flag not cleared");
   mem_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !wr_hit && !handler_enter.memory_fault && !handler_return.memory_fault |=>
      $stable(active_flags.memory_fault)) else $error("memory flag moved");
   reset_zero_a: assert property (@(posedge sys_clk)
      $rose(arst_n) |-> active_flags == '0) else $error("flags not zero at reset");
   enter_wins_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (handler_enter != '0) |=> (active_flags & $past(handler_enter)) == $past(handler_enter))
      else $error("entry lost");

   sw_write_c: cover property (@(posedge sys_clk) disable iff (!arst_n) wr_hit);
   enter_ret_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
      handler_enter.supervisor_call ##[1:10] handler_return.supervisor_call);
   read_set_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
      rd_hit && prdata[SHAS_PSV_BIT]);
   dbg_race_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
      handler_return.debug_monitor && wr_hit);
   mem_write_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
      wr_hit && pwdata[SHAS_MEM_BIT]);

   // pendable-service entry and return checks, write checks for the other five flags
   psv_enter_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      handler_enter.pendable_service |=> active_flags.pendable_service)
      else $error("pendable flag not set");
   psv_return_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      handler_return.pendable_service && !handler_enter.pendable_service |=>
      !active_flags.pendable_service) else $error("pendable flag not cleared");
   dbg_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_hit && !handler_enter.debug_monitor && !handler_return.debug_monitor |=>
      active_flags.debug_monitor == past_wval.debug_monitor)
      else $error("monitor write lost");
   svc_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_hit && !handler_enter.supervisor_call && !handler_return.supervisor_call |=>
      active_flags.supervisor_call == past_wval.supervisor_call)
      else $error("svc write lost");
   usage_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_hit && !handler_enter.usage_fault && !handler_return.usage_fault |=>
      active_flags.usage_fault == past_wval.usage_fault)
      else $error("usage write lost");
   bus_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_hit && !handler_enter.bus_fault && !handler_return.bus_fault |=>
      active_flags.bus_fault == past_wval.bus_fault)
      else $error("bus write lost");
   mem_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_hit && !handler_enter.memory_fault && !handler_return.memory_fault |=>
      active_flags.memory_fault == past_wval.memory_fault)
      else $error("memory write lost");

   // reset and read word checks
   reset_flags_a: assert property (@(posedge sys_clk)
      !arst_n |-> active_flags == '0) else $error("flags not held in reset");
   reset_rdata_a: assert property (@(posedge sys_clk)
      !arst_n |-> prdata == 32'h0000_0000) else $error("read data not cleared");
   read_word_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      rd_hit |-> prdata == $past(state_word)) else $error("read word wrong");
endmodule
`default_nettype wire

//--- system_handler_active_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module system_handler_active_status_tb;
   import shas_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   shas_flags_type handler_enter = '0;
   shas_flags_type handler_return = '0;
   shas_flags_type active_flags;
   int err_count = 0;
   int checks = 0;
   logic [31:0] rd;
   logic er;
   localparam logic [11:0] A = SHAS_STATE_OFFSET;

   always #2 sys_clk = ~sys_clk;

   shas_system_handler_active_status shas_system_handler_active_status_inst (
      .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .handler_enter(handler_enter), .handler_return(handler_return),
      .active_flags(active_flags));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // flag struct placed at its register bit positions
   function automatic logic [31:0] to_reg(input shas_flags_type f);
      return {21'h0, f.pendable_service, 1'b0, f.debug_monitor, f.supervisor_call, 3'h0,
         f.usage_fault, 1'b0, f.bus_fault, f.memory_fault};
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      check("pready", {31'h0, pready}, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulse(input shas_flags_type e, input shas_flags_type r);
      @(posedge sys_clk);
      handler_enter <= e;
      handler_return <= r;
      @(posedge sys_clk);
      handler_enter <= '0;
      handler_return <= '0;
   endtask

   task automatic t_bits();
      logic [31:0] v;
      for (int i = 0; i < 33; i++)
      begin
         v = (i == 32) ? 32'hffff_ffff : 32'h1 << i;
         apb(1'b1, A, v);
         apb(1'b0, A, 32'h0);
         check("state", rd, v & 32'h0000_058b);
         check("flags", to_reg(active_flags), v & 32'h0000_058b);
      end
   endtask

   task automatic t_misc();
      pulse('0, '1);
      apb(1'b0, A, 32'h0);
      check("return", rd, 32'h0);
      pulse('1, '0);
      apb(1'b0, A, 32'h0);
      check("enter", rd, 32'h0000_058b);
      apb(1'b1, 12'hd28, 32'h0);
      check("unmapped err", {31'h0, er}, 32'h1);
      apb(1'b0, A, 32'h0);
      check("unmapped write", rd, 32'h0000_058b);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("flags in reset", to_reg(active_flags), 32'h0);
      arst_n <= 1'b1;
      apb(1'b0, A, 32'h0);
      check("after reset", rd, 32'h0);
   endtask

   task automatic finish_test();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      apb(1'b0, A, 32'h0);
      check("reset value", rd, 32'h0);
      t_bits();
      t_misc();
      finish_test();
   end

   // whole run is a few hundred cycles
   initial
   begin
      #20000;
      err_count++;
      finish_test();
   end
endmodule
`default_nettype wire
